// [pkg/iwu_defs.vh]
// Shared constants of the interrupt and watchdog unit.
`ifndef IWU_DEFS_VH
`define IWU_DEFS_VH
// Fetch addresses handed to the core.
`define IWU_VEC_W       11
`define IWU_VEC_TRAP    11'h001
`define IWU_VEC_HW      11'h008
// Register word indices, byte address is four times the index.
`define IWU_A_FLAG      3'h0
`define IWU_A_EN        3'h1
`define IWU_A_PWR       3'h2
`define IWU_A_PRE       3'h3
`define IWU_A_CFG       3'h4
`define IWU_A_WAKE      3'h5
`define IWU_A_EXT       3'h6
`define IWU_A_STAT      3'h7
// Flag and enable bit positions.
`define IWU_B_T0        0
`define IWU_B_PB        1
`define IWU_B_EXT       2
`define IWU_B_T1        3
`define IWU_B_WDT       6
`define IWU_FLAG_MASK   8'h4f
// Control bit positions.
`define IWU_B_RUN       7
`define IWU_B_PRE_WDT   3
`define IWU_B_CFG_EN    0
`define IWU_B_CFG_IRQ   1
`define IWU_B_PER_LO    2
`define IWU_B_EXT_SEL   0
`define IWU_B_EDGE      1
`define IWU_B_TO_N      4
`define IWU_B_GIE       0
// Reset values.
`define IWU_RST_BYTE    8'h00
`define IWU_RST_PWR     8'h80
// Watchdog base periods in microseconds.
`define IWU_T_WDT0_US   64'd3500
`define IWU_T_WDT1_US   64'd15000
`define IWU_T_WDT2_US   64'd60000
`define IWU_T_WDT3_US   64'd250000
`define IWU_US_PER_S    64'd1000000
// Prescaler ratio base per timeout mechanism.
`define IWU_PRE_BASE_RST 9'h001
`define IWU_PRE_BASE_IRQ 9'h002
`endif

// [design/iwu_sync.v]
// Two-flop synchroniser for signals entering from outside the clock domain.
`default_nettype none
module iwu_sync #(
  parameter W = 1
) (
  input  wire         i_ref_clk,
  input  wire         i_rst_n,
  input  wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);
  reg [W-1:0] stage1;
  reg [W-1:0] stage2;

  // Only the second stage is visible outside, to contain metastability.
  always @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      stage1 <= {W{1'b0}};
      stage2 <= {W{1'b0}};
    end
    else
    begin
      stage1 <= i_async;
      stage2 <= stage1;
    end
  end

  assign o_sync = stage2;
endmodule // iwu_sync
`default_nettype wire

// [design/iwu_wdog.v]
// Watchdog counter with the shared prescaler.
`default_nettype none
`include "iwu_defs.vh"
module iwu_wdog (
  input  wire        i_ref_clk,
  input  wire        i_rst_n,
  input  wire        i_tick,
  input  wire        i_cfg_en,
  input  wire        i_run_en,
  input  wire        i_irq_mode,
  input  wire [1:0]  i_period_sel,
  input  wire        i_pre_route,
  input  wire [2:0]  i_pre_sel,
  input  wire        i_clear,
  input  wire [31:0] i_lim0,
  input  wire [31:0] i_lim1,
  input  wire [31:0] i_lim2,
  input  wire [31:0] i_lim3,
  output reg         o_timeout
);
  reg  [31:0] cnt;
  reg  [8:0]  pre_cnt;
  reg  [31:0] limit;
  wire [8:0]  ratio;
  wire        pre_last;
  wire        base_tick;
  wire        running;

  // Reset mode divides 1:1..1:128, interrupt mode 1:2..1:256.
  assign ratio = (i_irq_mode ? `IWU_PRE_BASE_IRQ : `IWU_PRE_BASE_RST) << i_pre_sel;
  assign pre_last = (pre_cnt == ratio - 9'h001);
  assign base_tick = i_tick && (!i_pre_route || pre_last);
  assign running = i_cfg_en && i_run_en;

  // Base period choice.
  always @*
  begin
    case (i_period_sel)
      2'h0:    limit = i_lim0;
      2'h1:    limit = i_lim1;
      2'h2:    limit = i_lim2;
      default: limit = i_lim3;
    endcase
  end

  // Clear wins over counting so a clear on a tick edge is never lost.
  always @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt       <= 32'h0;
      pre_cnt   <= 9'h0;
      o_timeout <= 1'b0;
    end
    else if (i_clear)
    begin
      cnt       <= 32'h0;
      pre_cnt   <= 9'h0;
      o_timeout <= 1'b0;
    end
    else
    begin
      o_timeout <= 1'b0;
      if (running && i_tick && i_pre_route)
        pre_cnt <= pre_last ? 9'h0 : pre_cnt + 9'h001;
      if (running && base_tick)
      begin
        if (cnt >= limit - 32'h1)
        begin
          cnt       <= 32'h0;
          o_timeout <= 1'b1;
        end
        else
          cnt <= cnt + 32'h1;
      end
    end
  end
endmodule // iwu_wdog
`default_nettype wire

// [design/iwu_top.v]
// Interrupt control and watchdog unit with an Avalon-MM register slave.
`default_nettype none
`include "iwu_defs.vh"
// Functional notes
// - Soft trap vectors to 0x001, clears global enable
// - Enable/disable instructions set/clear global enable
// - Return instruction sets global enable, resumes
// - Events set sticky flags, cleared by writing 0
// - Flags read set only when enabled
// - Enabled pending flag vectors to 0x008
// - Timer zero overflow sets its flag
// - Timer one underflow sets its flag
// - Enabled input pin change sets change flag
// - External select masks pin zero change
// - Selected pin zero edge sets external flag
// - Watchdog counting gated by run enable
// - Timeout resets or interrupts, clears timeout flag
// - Base period selectable among four values
// - Shared prescaler divides watchdog when routed
// - Clear instruction clears counter, prescaler, sets flag
// - Interrupt mode timeout sets watchdog flag
// - Watchdog runs from its own oscillator
// - Timer zero flag and enable at bit 0
// - Timer one flag and enable at bit 3
// - Halt entry clears watchdog counter
module iwu_top #(
  parameter [63:0] WDT_OSC_HZ = 64'd32768,
  parameter [63:0] WDT_LIM0   = (`IWU_T_WDT0_US * WDT_OSC_HZ + `IWU_US_PER_S - 64'd1) / `IWU_US_PER_S,
  parameter [63:0] WDT_LIM1   = (`IWU_T_WDT1_US * WDT_OSC_HZ + `IWU_US_PER_S - 64'd1) / `IWU_US_PER_S,
  parameter [63:0] WDT_LIM2   = (`IWU_T_WDT2_US * WDT_OSC_HZ + `IWU_US_PER_S - 64'd1) / `IWU_US_PER_S,
  parameter [63:0] WDT_LIM3   = (`IWU_T_WDT3_US * WDT_OSC_HZ + `IWU_US_PER_S - 64'd1) / `IWU_US_PER_S
) (
  input  wire                  i_ref_clk,
  input  wire                  i_reset_n,
  input  wire [4:0]            i_address,
  input  wire                  i_read,
  input  wire                  i_write,
  input  wire [31:0]           i_writedata,
  input  wire [3:0]            i_byteenable,
  output reg  [31:0]           o_readdata,
  output reg                   o_waitrequest,
  input  wire                  i_soft_trap,
  input  wire                  i_irq_enable_instr,
  input  wire                  i_irq_disable_instr,
  input  wire                  i_irq_return_instr,
  input  wire                  i_watchdog_clear_instr,
  input  wire                  i_halt_enter,
  input  wire                  i_tmr_zero_ovf,
  input  wire                  i_tmr_one_udf,
  input  wire [7:0]            i_port_b_pin,
  input  wire [7:0]            i_port_b_is_input,
  input  wire                  i_wdt_osc,
  output reg                   o_vector_valid,
  output reg  [`IWU_VEC_W-1:0] o_vector_addr,
  output reg                   o_resume,
  output reg                   o_global_irq_enable,
  output reg                   o_irq_pending,
  output reg                   o_wdt_reset
);
  // Reset release synchroniser.
  reg        rst_meta;
  reg        rst_n;

  // Software visible state.
  reg [7:0]  irq_flag_reg;
  reg [7:0]  irq_enable_reg;
  reg [7:0]  power_ctrl_reg;
  reg [7:0]  pre_ctrl;
  reg [7:0]  wdt_cfg;
  reg [7:0]  port_b_wake_enable;
  reg [7:0]  ext_ctrl;
  reg        timeout_flag_n;

  // Edge detection history.
  reg [7:0]  pb_prev;
  reg        osc_prev;

  wire [7:0] pb_sync;
  wire       osc_sync;
  wire       wdt_tick;
  wire       wdt_timeout;
  wire       bus_req;
  wire       wr_go;
  wire [2:0] word_idx;
  wire       ext_irq_select;
  wire       ext_edge_sel;
  wire       wdt_irq_mode;
  wire [7:0] change_mask;
  wire       portb_change_evt;
  wire       ext_evt;
  wire [7:0] flag_set;
  wire [7:0] flag_seen;
  wire       hw_request;
  reg  [31:0] next_readdata;
  reg  [7:0]  next_flags;

  // The rest of the design sees a reset whose release is clean.
  always @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Port B pins and the watchdog oscillator come from outside the clock.
  iwu_sync #(.W(8)) u_pb_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (rst_n),
    .i_async   (i_port_b_pin),
    .o_sync    (pb_sync)
  );

  iwu_sync #(.W(1)) u_osc_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (rst_n),
    .i_async   (i_wdt_osc),
    .o_sync    (osc_sync)
  );

  // History of synchronised inputs for edge and change detection.
  always @(posedge i_ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pb_prev  <= 8'h00;
      osc_prev <= 1'b0;
    end
    else
    begin
      pb_prev  <= pb_sync;
      osc_prev <= osc_sync;
    end
  end

  // Each rising edge of the free-running oscillator is one watchdog tick.
  // It is sampled, not used as a clock, so the oscillator must stay well
  // below half the system clock rate.
  assign wdt_tick = osc_sync && !osc_prev;

  assign ext_irq_select = ext_ctrl[`IWU_B_EXT_SEL];
  assign ext_edge_sel   = ext_ctrl[`IWU_B_EDGE];
  assign wdt_irq_mode   = wdt_cfg[`IWU_B_CFG_IRQ];

  // Pin zero leaves the change group while it serves the external edge.
  assign change_mask = port_b_wake_enable & i_port_b_is_input &
                       {7'h7f, !ext_irq_select};
  assign portb_change_evt = |((pb_sync ^ pb_prev) & change_mask);

  // One means rising edge, zero falling edge.
  assign ext_evt = ext_irq_select &&
                   (ext_edge_sel ? (pb_sync[0] && !pb_prev[0])
                                 : (!pb_sync[0] && pb_prev[0]));

  // Hardware events that set flags this cycle.
  assign flag_set = ({7'h00, i_tmr_zero_ovf} << `IWU_B_T0) |
                    ({7'h00, portb_change_evt} << `IWU_B_PB) |
                    ({7'h00, ext_evt} << `IWU_B_EXT) |
                    ({7'h00, i_tmr_one_udf} << `IWU_B_T1) |
                    ({7'h00, wdt_timeout && wdt_irq_mode} << `IWU_B_WDT);

  // Flags appear to software and to the core only through their enables.
  assign flag_seen  = irq_flag_reg & irq_enable_reg;
  assign hw_request = |flag_seen;

  // Bus decode.
  assign bus_req  = i_read || i_write;
  assign wr_go    = i_write && !o_waitrequest && i_byteenable[0];
  assign word_idx = i_address[4:2];

  // Watchdog counter and prescaler.
  iwu_wdog u_wdog (
    .i_ref_clk    (i_ref_clk),
    .i_rst_n      (rst_n),
    .i_tick       (wdt_tick),
    .i_cfg_en     (wdt_cfg[`IWU_B_CFG_EN]),
    .i_run_en     (power_ctrl_reg[`IWU_B_RUN]),
    .i_irq_mode   (wdt_irq_mode),
    .i_period_sel (wdt_cfg[`IWU_B_PER_LO+1:`IWU_B_PER_LO]),
    .i_pre_route  (pre_ctrl[`IWU_B_PRE_WDT]),
    .i_pre_sel    (pre_ctrl[2:0]),
    .i_clear      (i_watchdog_clear_instr || i_halt_enter),
    .i_lim0       (WDT_LIM0[31:0]),
    .i_lim1       (WDT_LIM1[31:0]),
    .i_lim2       (WDT_LIM2[31:0]),
    .i_lim3       (WDT_LIM3[31:0]),
    .o_timeout    (wdt_timeout)
  );

  // Flag update: a write of 0 clears, a write of 1 keeps, and an event in
  // the same cycle as the clearing write wins.
  always @*
  begin
    next_flags = irq_flag_reg;
    if (wr_go && word_idx == `IWU_A_FLAG)
      next_flags = irq_flag_reg & i_writedata[7:0];
    next_flags = (next_flags | flag_set) & `IWU_FLAG_MASK;
  end

  // Read data multiplexer; unmapped bits read as zero.
  always @*
  begin
    next_readdata = 32'h0;
    case (word_idx)
      `IWU_A_FLAG: next_readdata[7:0] = flag_seen;
      `IWU_A_EN:   next_readdata[7:0] = irq_enable_reg;
      `IWU_A_PWR:  next_readdata[7:0] = power_ctrl_reg;
      `IWU_A_PRE:  next_readdata[7:0] = pre_ctrl;
      `IWU_A_CFG:  next_readdata[7:0] = wdt_cfg;
      `IWU_A_WAKE: next_readdata[7:0] = port_b_wake_enable;
      `IWU_A_EXT:  next_readdata[7:0] = ext_ctrl;
      `IWU_A_STAT:
      begin
        next_readdata[`IWU_B_TO_N] = timeout_flag_n;
        next_readdata[`IWU_B_GIE]  = o_global_irq_enable;
      end
      default:     next_readdata = 32'h0;
    endcase
  end

  // Bus slave: every access waits exactly one cycle, then completes.
  always @(posedge i_ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_waitrequest <= 1'b1;
      o_readdata    <= 32'h0;
    end
    else if (bus_req && o_waitrequest)
    begin
      o_waitrequest <= 1'b0;
      o_readdata    <= next_readdata;
    end
    else
    begin
      o_waitrequest <= 1'b1;
    end
  end

  // Control registers written by software.
  always @(posedge i_ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_flag_reg       <= `IWU_RST_BYTE;
      irq_enable_reg     <= `IWU_RST_BYTE;
      power_ctrl_reg     <= `IWU_RST_PWR;
      pre_ctrl           <= `IWU_RST_BYTE;
      wdt_cfg            <= `IWU_RST_BYTE;
      port_b_wake_enable <= `IWU_RST_BYTE;
      ext_ctrl           <= `IWU_RST_BYTE;
    end
    else
    begin
      irq_flag_reg <= next_flags;
      if (wr_go)
      begin
        case (word_idx)
          `IWU_A_EN:   irq_enable_reg     <= i_writedata[7:0] & `IWU_FLAG_MASK;
          `IWU_A_PWR:  power_ctrl_reg     <= i_writedata[7:0];
          `IWU_A_PRE:  pre_ctrl           <= i_writedata[7:0];
          `IWU_A_CFG:  wdt_cfg            <= i_writedata[7:0];
          `IWU_A_WAKE: port_b_wake_enable <= i_writedata[7:0];
          `IWU_A_EXT:  ext_ctrl           <= i_writedata[7:0];
          default:     ext_ctrl           <= ext_ctrl;
        endcase
      end
    end
  end

  // Timeout status: low after expiry, back high on clear or halt entry.
  // Expiry wins if it lands in the same cycle as a clear.
  always @(posedge i_ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      timeout_flag_n <= 1'b1;
    else if (wdt_timeout)
      timeout_flag_n <= 1'b0;
    else if (i_watchdog_clear_instr || i_halt_enter)
      timeout_flag_n <= 1'b1;
  end

  // Reset-mode expiry asks the system for a one-cycle reset pulse.
  always @(posedge i_ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      o_wdt_reset <= 1'b0;
    else
      o_wdt_reset <= wdt_timeout && !wdt_irq_mode;
  end

  // Global enable and vectoring. The trap wins over everything; a hardware
  // vector clears the global enable at once, so it fires a single pulse
  // even while the flag stays set.
  always @(posedge i_ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_global_irq_enable <= 1'b0;
      o_vector_valid      <= 1'b0;
      o_vector_addr       <= `IWU_VEC_TRAP;
      o_resume            <= 1'b0;
      o_irq_pending       <= 1'b0;
    end
    else
    begin
      o_vector_valid <= 1'b0;
      o_resume       <= 1'b0;
      o_irq_pending  <= hw_request;
      if (i_soft_trap)
      begin
        o_vector_valid      <= 1'b1;
        o_vector_addr       <= `IWU_VEC_TRAP;
        o_global_irq_enable <= 1'b0;
      end
      else if (i_irq_return_instr)
      begin
        o_resume            <= 1'b1;
        o_global_irq_enable <= 1'b1;
      end
      else if (i_irq_enable_instr)
        o_global_irq_enable <= 1'b1;
      else if (i_irq_disable_instr)
        o_global_irq_enable <= 1'b0;
      else if (hw_request && o_global_irq_enable)
      begin
        o_vector_valid      <= 1'b1;
        o_vector_addr       <= `IWU_VEC_HW;
        o_global_irq_enable <= 1'b0;
      end
    end
  end
endmodule // iwu_top
`default_nettype wire

// [test/iwu_monitor.sv]
// Checker of the unit's vectoring, global enable and bus handshake.
`default_nettype none
`include "iwu_defs.vh"
module iwu_monitor (
  input wire logic                  i_ref_clk,
  input wire logic                  i_reset_n,
  input wire logic                  i_read,
  input wire logic                  i_write,
  input wire logic                  i_soft_trap,
  input wire logic                  i_irq_enable_instr,
  input wire logic                  i_irq_disable_instr,
  input wire logic                  i_irq_return_instr,
  input wire logic                  o_waitrequest,
  input wire logic                  o_vector_valid,
  input wire logic [`IWU_VEC_W-1:0] o_vector_addr,
  input wire logic                  o_resume,
  input wire logic                  o_global_irq_enable,
  input wire logic                  o_irq_pending
);
  timeunit 1ns;
  timeprecision 1ps;
  wire any_op;
  // Any trap, enable, disable or return strobe outranks a hardware vector in its cycle.
  assign any_op = i_soft_trap | i_irq_enable_instr | i_irq_disable_instr | i_irq_return_instr;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  // Strobes act one cycle later; pending lags the flags by one cycle, so the vector is tied to it.
  trap_vector_a : assert property (i_soft_trap |=> o_vector_valid && o_vector_addr == `IWU_VEC_TRAP)
    else $error("trap did not vector to its address");
  gie_set_a : assert property (i_irq_enable_instr && !i_soft_trap |=> o_global_irq_enable)
    else $error("enable instruction did not set global enable");
  gie_clear_a : assert property (i_irq_disable_instr && !(i_soft_trap || i_irq_enable_instr || i_irq_return_instr)
    |=> !o_global_irq_enable)
    else $error("disable instruction did not clear global enable");
  return_resume_a : assert property (i_irq_return_instr && !i_soft_trap |=> o_resume && o_global_irq_enable)
    else $error("return did not resume with global enable set");
  gie_hold_a : assert property (!any_op ##1 !o_vector_valid |-> $stable(o_global_irq_enable))
    else $error("global enable moved without a cause");
  hw_vector_a : assert property ((o_vector_valid && o_vector_addr == `IWU_VEC_HW) |->
    $past(o_global_irq_enable) && !$past(any_op) && o_irq_pending && !o_global_irq_enable)
    else $error("hardware vector without an enabled pending flag");
  pending_vector_a : assert property (o_global_irq_enable && !any_op ##1 o_irq_pending |-> o_vector_valid)
    else $error("enabled pending flag was not vectored");
  bus_answer_a : assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest ##1 o_waitrequest)
    else $error("bus access not answered in one cycle");
endmodule // iwu_monitor
bind iwu_top iwu_monitor i_iwu_monitor (
  .i_ref_clk, .i_reset_n, .i_read, .i_write, .i_soft_trap, .i_irq_enable_instr, .i_irq_disable_instr,
  .i_irq_return_instr, .o_waitrequest, .o_vector_valid, .o_vector_addr, .o_resume, .o_global_irq_enable,
  .o_irq_pending
);
`default_nettype wire

// [test/iwu_core_model.sv]
// Behavioural core that issues one instruction strobe per request.
`default_nettype none
module iwu_core_model (
  input  wire logic       i_ref_clk,
  input  wire logic       i_go,
  input  wire logic [2:0] i_op,
  output logic      [5:0] o_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_strobe = 6'h00;
  // Strobe bit n stands for opcode n for one cycle; a return straight after an
  // enable is dropped, since firmware must never place the two back to back.
  always @(posedge i_ref_clk)
  begin
    if (i_go && !(i_op == 3'h3 && o_strobe[1]))
      o_strobe <= 6'h01 << i_op;
    else
      o_strobe <= 6'h00;
  end
endmodule // iwu_core_model
`default_nettype wire

// [test/iwu_top_tb.sv]
// Self-checking bench of the interrupt and watchdog unit.
`default_nettype none
`include "iwu_defs.vh"
module iwu_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  ref_clk = 1'b0;
  logic                  reset_n = 1'b0;
  logic                  rd      = 1'b0;
  logic                  wr      = 1'b0;
  logic                  go      = 1'b0;
  logic                  osc     = 1'b0;
  logic [2:0]            op      = 3'h0;
  logic [1:0]            tmr     = 2'h0;
  logic [7:0]            pins    = 8'h00;
  logic [7:0]            is_in   = 8'hff;
  logic [4:0]            addr    = 5'h00;
  logic [31:0]           wdata   = 32'h0;
  logic [31:0]           rdata;
  logic [5:0]            strobe;
  logic [`IWU_VEC_W-1:0] vaddr;
  logic                  waitreq, vvalid, resume, global_irq_enable, pend, wrst;
  int                    errors = 0, compares = 0, wcnt = 0, cyc = 0;
  logic [31:0]           rq[$];
  logic [`IWU_VEC_W-1:0] vq[$];
  // System clock, and a slow free-running watchdog oscillator of eight clocks.
  always #2 ref_clk = ~ref_clk;
  always
  begin
    repeat (4) @(posedge ref_clk);
    osc <= ~osc;
  end
  iwu_top #(.WDT_LIM0(64'h4), .WDT_LIM1(64'h5), .WDT_LIM2(64'h6), .WDT_LIM3(64'h7)) i_iwu_top (
    .i_ref_clk(ref_clk), .i_reset_n(reset_n), .i_address(addr), .i_read(rd), .i_write(wr),
    .i_writedata(wdata), .i_byteenable(4'hf), .o_readdata(rdata), .o_waitrequest(waitreq),
    .i_soft_trap(strobe[0]), .i_irq_enable_instr(strobe[1]), .i_irq_disable_instr(strobe[2]),
    .i_irq_return_instr(strobe[3]), .i_watchdog_clear_instr(strobe[4]), .i_halt_enter(strobe[5]),
    .i_tmr_zero_ovf(tmr[0]), .i_tmr_one_udf(tmr[1]), .i_port_b_pin(pins), .i_port_b_is_input(is_in),
    .i_wdt_osc(osc), .o_vector_valid(vvalid), .o_vector_addr(vaddr), .o_resume(resume),
    .o_global_irq_enable(global_irq_enable), .o_irq_pending(pend), .o_wdt_reset(wrst));
  iwu_core_model i_iwu_core_model (.i_ref_clk(ref_clk), .i_go(go), .i_op(op), .o_strobe(strobe));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask
  // One transfer, held until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    rd    <= !w;
    wr    <= w;
    addr  <= {a, 2'b00};
    wdata <= {24'h0, d};
    do @(posedge ref_clk); while (waitreq !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rreg(input logic [2:0] a, input logic [7:0] e);
    rq.push_back({24'h0, e});
    bus(1'b0, a, 8'h00);
  endtask
  task automatic core(input logic [2:0] c);
    @(posedge ref_clk);
    go <= 1'b1;
    op <= c;
    @(posedge ref_clk);
    go <= 1'b0;
  endtask
  task automatic evt(input logic [1:0] m);
    @(posedge ref_clk);
    tmr <= m;
    @(posedge ref_clk);
    tmr <= 2'h0;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic stop_test();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Results are matched against the oldest note as they appear; a hang is cut short.
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (rd && waitreq === 1'b0)
      check(rdata, rq.pop_front());
    if (vvalid === 1'b1)
      check({21'h0, vaddr}, {21'h0, vq.pop_front()});
    if (wrst === 1'b1)
      wcnt++;
    if (cyc == 6000)
    begin
      errors++;
      stop_test();
    end
  end
  initial
  begin
    void'($urandom(32'h3b6770d0));
    wt(12);
    reset_n <= 1'b1;
    wt(3);
    rreg(`IWU_A_STAT, 8'h10);
    rreg(`IWU_A_PWR, 8'h80);
    core(3'h1);
    rreg(`IWU_A_STAT, 8'h11);
    vq.push_back(`IWU_VEC_TRAP);
    core(3'h0);
    rreg(`IWU_A_STAT, 8'h10);
    core(3'h3);
    rreg(`IWU_A_STAT, 8'h11);
    core(3'h2);
    rreg(`IWU_A_STAT, 8'h10);
    $display("test global enable done");
    wreg(`IWU_A_EN, 8'hff);
    rreg(`IWU_A_EN, 8'h4f);
    evt(2'h1);
    evt(2'h2);
    rreg(`IWU_A_FLAG, 8'h09);
    wreg(`IWU_A_FLAG, 8'hff);
    rreg(`IWU_A_FLAG, 8'h09);
    wreg(`IWU_A_EN, 8'h01);
    rreg(`IWU_A_FLAG, 8'h01);
    wreg(`IWU_A_FLAG, 8'hf7);
    wreg(`IWU_A_EN, 8'h4f);
    rreg(`IWU_A_FLAG, 8'h01);
    vq.push_back(`IWU_VEC_HW);
    core(3'h1);
    // The enable lands one edge before the vector clears it again, so let both pass.
    wt(2);
    rreg(`IWU_A_STAT, 8'h10);
    wreg(`IWU_A_FLAG, 8'h00);
    core(3'h3);
    core(3'h2);
    $display("test flags done");
    wreg(`IWU_A_WAKE, 8'h02);
    repeat (4)
    begin
      @(posedge ref_clk) pins <= 8'($urandom) & 8'hfd;
      wt(3);
    end
    wt(6);
    rreg(`IWU_A_FLAG, 8'h00);
    @(posedge ref_clk) pins <= pins ^ 8'h02;
    wt(6);
    rreg(`IWU_A_FLAG, 8'h02);
    wreg(`IWU_A_FLAG, 8'h00);
    @(posedge ref_clk) is_in <= 8'hfd;
    @(posedge ref_clk) pins <= pins ^ 8'h02;
    wt(6);
    rreg(`IWU_A_FLAG, 8'h00);
    wreg(`IWU_A_WAKE, 8'h01);
    wreg(`IWU_A_EXT, 8'h03);
    @(posedge ref_clk) pins <= 8'h00;
    wt(6);
    wreg(`IWU_A_FLAG, 8'h00);
    @(posedge ref_clk) pins <= 8'h01;
    wt(6);
    rreg(`IWU_A_FLAG, 8'h04);
    wreg(`IWU_A_FLAG, 8'h00);
    @(posedge ref_clk) pins <= 8'h00;
    wt(6);
    rreg(`IWU_A_FLAG, 8'h00);
    // Falling-edge selection: a rising edge is ignored, a falling one flags.
    wreg(`IWU_A_EXT, 8'h01);
    @(posedge ref_clk) pins <= 8'h01;
    wt(6);
    rreg(`IWU_A_FLAG, 8'h00);
    @(posedge ref_clk) pins <= 8'h00;
    wt(6);
    rreg(`IWU_A_FLAG, 8'h04);
    wreg(`IWU_A_FLAG, 8'h00);
    $display("test port b done");
    wreg(`IWU_A_CFG, 8'h03);
    core(3'h4);
    wt(60);
    rreg(`IWU_A_FLAG, 8'h40);
    rreg(`IWU_A_STAT, 8'h00);
    core(3'h4);
    rreg(`IWU_A_STAT, 8'h10);
    wreg(`IWU_A_PWR, 8'h00);
    core(3'h4);
    wreg(`IWU_A_FLAG, 8'h00);
    wt(80);
    rreg(`IWU_A_FLAG, 8'h00);
    wreg(`IWU_A_CFG, 8'h01);
    wreg(`IWU_A_PRE, 8'h09);
    wreg(`IWU_A_PWR, 8'h80);
    core(3'h4);
    wt(40);
    check(wcnt, 0);
    wt(60);
    check(wcnt, 1);
    core(3'h4);
    wt(40);
    core(3'h5);
    wt(40);
    check(wcnt, 1);
    // Longest base period, unscaled: seven ticks, so the first check is early.
    wreg(`IWU_A_PWR, 8'h00);
    wreg(`IWU_A_PRE, 8'h00);
    wreg(`IWU_A_CFG, 8'h0d);
    wreg(`IWU_A_PWR, 8'h80);
    core(3'h4);
    wt(40);
    check(wcnt, 1);
    wt(30);
    check(wcnt, 2);
    $display("test watchdog done");
    check(vq.size(), 0);
    stop_test();
  end
endmodule // iwu_top_tb
`default_nettype wire
